// >>> pkg/bbf_pkg.sv
// Constants, opcodes and types for the branch, bit and flag execution slice.
// Assumes a core that presents one decoded instruction at a time.
package bbf_pkg;

  // Status register bit positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Program counter steps, in words, and the branch offset width in bits
  localparam int PC_STEP = 1;
  localparam int SKIP_SHORT = 2;
  localparam int SKIP_LONG = 3;
  localparam int OFFSET_W = 7;

  // Avalon-MM word addresses and status register bit positions
  localparam logic [1:0] ADDR_FLAGS = 2'h0;
  localparam logic [1:0] ADDR_LAST_PC = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_TAKEN = 1;

  typedef enum logic [5:0] {
    op_compare_regs, op_compare_with_borrow, op_compare_immediate,
    op_skip_reg_bit_clear, op_skip_reg_bit_set, op_skip_io_bit_clear, op_skip_io_bit_set,
    op_branch_flag_set, op_branch_flag_clear, op_branch_equal, op_branch_not_equal,
    op_branch_carry_set, op_branch_carry_clear, op_branch_same_or_higher, op_branch_lower,
    op_branch_minus, op_branch_plus, op_branch_signed_ge, op_branch_signed_lt,
    op_branch_half_carry_set, op_branch_half_carry_clear, op_branch_overflow_clear,
    op_branch_irq_enabled, op_branch_irq_disabled,
    op_set_io_bit, op_clear_io_bit,
    op_shift_left_zero_fill, op_shift_right_zero_fill, op_rotate_left_carry,
    op_rotate_right_carry, op_arith_shift_right, op_nibble_swap,
    op_status_bit_set, op_status_bit_clear, op_store_bit_to_transfer,
    op_load_bit_from_transfer,
    op_set_carry_flag, op_clear_carry_flag, op_set_negative_flag, op_clear_negative_flag,
    op_set_zero_flag, op_clear_zero_flag, op_irq_global_on, op_irq_global_off,
    op_set_sign_flag, op_clear_sign_flag, op_set_overflow_flag
  } opcode_t;

  typedef enum logic [2:0] {
    alu_sub, alu_shl, alu_shr, alu_rotl, alu_rotr, alu_shr_arith
  } alu_op_t;

  typedef enum logic [1:0] {
    st_idle = 2'h1,
    st_hold = 2'h2
  } exec_state_t;

endpackage

// >>> pkg/alu_if.sv
// Operand and result bundle between the executor and its shift/compare unit.
// Assumes both ends run in the same clock domain; the bundle is combinational.
`timescale 1ns/1ps
interface alu_if;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic zin;
  bbf_pkg::alu_op_t op;
  logic [7:0] res;
  logic c;
  logic z;
  logic n;
  logic v;
  logic h;
  modport alu (input a, b, cin, zin, op, output res, c, z, n, v, h);
  modport user (output a, b, cin, zin, op, input res, c, z, n, v, h);
endinterface

// >>> src/bbf_shift_compare.sv
// Combinational subtract-compare and shift/rotate unit with flag results.
// Assumes the caller registers results and picks which flags to keep.
`timescale 1ns/1ps
module bbf_shift_compare (
  alu_if.alu alu
);

  logic [7:0] diff;

  always_comb
  begin
    diff = alu.a - alu.b - {7'h00, alu.cin};
    alu.res = 8'h00;
    alu.c = 1'b0;
    alu.h = 1'b0;
    case (alu.op)
      bbf_pkg::alu_sub:
      begin
        alu.res = diff;
        alu.c = (~alu.a[7] & alu.b[7]) | (alu.b[7] & diff[7]) | (diff[7] & ~alu.a[7]);
        alu.h = (~alu.a[3] & alu.b[3]) | (alu.b[3] & diff[3]) | (diff[3] & ~alu.a[3]);
      end
      bbf_pkg::alu_shl:
      begin
        alu.res = {alu.a[6:0], 1'b0};
        alu.c = alu.a[7];
      end
      bbf_pkg::alu_shr:
      begin
        alu.res = {1'b0, alu.a[7:1]};
        alu.c = alu.a[0];
      end
      bbf_pkg::alu_rotl:
      begin
        alu.res = {alu.a[6:0], alu.cin};
        alu.c = alu.a[7];
      end
      bbf_pkg::alu_rotr:
      begin
        alu.res = {alu.cin, alu.a[7:1]};
        alu.c = alu.a[0];
      end
      bbf_pkg::alu_shr_arith:
      begin
        alu.res = {alu.a[7], alu.a[7:1]};
        alu.c = alu.a[0];
      end
      default:
      begin
        alu.res = 8'h00;
      end
    endcase
    alu.n = alu.res[7];
    // Chained compare keeps Z only if every earlier byte was equal too
    alu.z = alu.zin & (alu.res == 8'h00);
    if (alu.op == bbf_pkg::alu_sub)
      alu.v = (alu.a[7] & ~alu.b[7] & ~diff[7]) | (~alu.a[7] & alu.b[7] & diff[7]);
    else
      alu.v = alu.res[7] ^ alu.c;
  end

endmodule

// >>> src/bbf_exec.sv
// Executor for compares, skips, flag branches, I/O bit set/clear, shifts and flag ops.
// Assumes the core presents decoded operands and waits on ready; the flags live here.
//
// Overview of operation
// - Compares subtract, set ZNVCH, write nothing, one cycle
// - Register bit skip adds two or three
// - I/O bit skip adds two or three
// - Indexed flag branch jumps to PC+k+1
// - Equal branches follow zero flag
// - Carry branches follow carry flag
// - Minus and plus follow negative flag
// - Half carry branches follow half carry
// - Overflow clear branch, one or two cycles
// - Interrupt state branches, one or two cycles
// - I/O bit set/clear, two cycles, no flags
// - Logical shifts fill zero, update ZCNV
// - Rotate left through carry
// - Rotate right through carry
// - Bit store copies register bit to T
// - Bit load writes T into register bit
// - Dedicated ops set or clear one flag
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module bbf_exec #(
  parameter int PC_W = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_exec_valid,
  output logic o_exec_ready,
  input wire bbf_pkg::opcode_t i_opcode,
  input wire logic [7:0] i_op_a,
  input wire logic [7:0] i_op_b,
  input wire logic [7:0] i_io_value,
  input wire logic [2:0] i_bit_sel,
  input wire logic [6:0] i_offset,
  input wire logic i_skip_long,
  input wire logic [PC_W-1:0] i_pc,
  output logic o_done,
  output logic [PC_W-1:0] o_pc_next,
  output logic o_reg_we,
  output logic [7:0] o_reg_data,
  output logic o_io_we,
  output logic [7:0] o_io_data,
  output logic [7:0] o_flags,
  input wire logic [1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);

  // Below eight bits the offset sign extension has no room
  if (PC_W < 8 || PC_W > 32)
  begin : g_pc_w_check
    $error("PC_W must lie between 8 and 32");
  end

  // Returns {is_branch, wanted level, flag index}
  function automatic logic [4:0] branch_decode(bbf_pkg::opcode_t op, logic [2:0] sel);
    case (op)
      bbf_pkg::op_branch_flag_set: return {2'b11, sel};
      bbf_pkg::op_branch_flag_clear: return {2'b10, sel};
      bbf_pkg::op_branch_equal: return {2'b11, bbf_pkg::FLAG_Z};
      bbf_pkg::op_branch_not_equal: return {2'b10, bbf_pkg::FLAG_Z};
      bbf_pkg::op_branch_carry_set: return {2'b11, bbf_pkg::FLAG_C};
      bbf_pkg::op_branch_lower: return {2'b11, bbf_pkg::FLAG_C};
      bbf_pkg::op_branch_carry_clear: return {2'b10, bbf_pkg::FLAG_C};
      bbf_pkg::op_branch_same_or_higher: return {2'b10, bbf_pkg::FLAG_C};
      bbf_pkg::op_branch_minus: return {2'b11, bbf_pkg::FLAG_N};
      bbf_pkg::op_branch_plus: return {2'b10, bbf_pkg::FLAG_N};
      bbf_pkg::op_branch_signed_ge: return {2'b10, bbf_pkg::FLAG_S};
      bbf_pkg::op_branch_signed_lt: return {2'b11, bbf_pkg::FLAG_S};
      bbf_pkg::op_branch_half_carry_set: return {2'b11, bbf_pkg::FLAG_H};
      bbf_pkg::op_branch_half_carry_clear: return {2'b10, bbf_pkg::FLAG_H};
      bbf_pkg::op_branch_overflow_clear: return {2'b10, bbf_pkg::FLAG_V};
      bbf_pkg::op_branch_irq_enabled: return {2'b11, bbf_pkg::FLAG_I};
      bbf_pkg::op_branch_irq_disabled: return {2'b10, bbf_pkg::FLAG_I};
      default: return 5'h00;
    endcase
  endfunction

  // Returns {is_flag_op, new value, flag index}
  function automatic logic [4:0] flag_decode(bbf_pkg::opcode_t op, logic [2:0] sel);
    case (op)
      bbf_pkg::op_status_bit_set: return {2'b11, sel};
      bbf_pkg::op_status_bit_clear: return {2'b10, sel};
      bbf_pkg::op_set_carry_flag: return {2'b11, bbf_pkg::FLAG_C};
      bbf_pkg::op_clear_carry_flag: return {2'b10, bbf_pkg::FLAG_C};
      bbf_pkg::op_set_negative_flag: return {2'b11, bbf_pkg::FLAG_N};
      bbf_pkg::op_clear_negative_flag: return {2'b10, bbf_pkg::FLAG_N};
      bbf_pkg::op_set_zero_flag: return {2'b11, bbf_pkg::FLAG_Z};
      bbf_pkg::op_clear_zero_flag: return {2'b10, bbf_pkg::FLAG_Z};
      bbf_pkg::op_irq_global_on: return {2'b11, bbf_pkg::FLAG_I};
      bbf_pkg::op_irq_global_off: return {2'b10, bbf_pkg::FLAG_I};
      bbf_pkg::op_set_sign_flag: return {2'b11, bbf_pkg::FLAG_S};
      bbf_pkg::op_clear_sign_flag: return {2'b10, bbf_pkg::FLAG_S};
      bbf_pkg::op_set_overflow_flag: return {2'b11, bbf_pkg::FLAG_V};
      default: return 5'h00;
    endcase
  endfunction

  alu_if alu_bus();

  bbf_shift_compare u_alu (
    .alu(alu_bus.alu)
  );

  bbf_pkg::exec_state_t state;
  bbf_pkg::exec_state_t next_state;
  logic [7:0] flags;
  logic [7:0] next_flags;
  logic [PC_W-1:0] next_pc_next;
  logic next_done;
  logic next_reg_we;
  logic [7:0] next_reg_data;
  logic next_io_we;
  logic [7:0] next_io_data;
  logic pend_io;
  logic next_pend_io;
  logic taken;
  logic next_taken;
  logic accept;
  logic [4:0] br;
  logic [4:0] fl;
  logic is_cmp;
  logic is_shift;
  logic bus_take;
  logic next_bus_take;
  logic [31:0] next_readdata;
  logic [PC_W-1:0] pc_seq;
  logic [PC_W-1:0] pc_skip;
  logic [PC_W-1:0] pc_branch;

  assign accept = i_exec_valid & o_exec_ready;
  assign o_exec_ready = (state == bbf_pkg::st_idle);
  assign o_flags = flags;
  assign br = branch_decode(i_opcode, i_bit_sel);
  assign fl = flag_decode(i_opcode, i_bit_sel);
  assign is_cmp = (i_opcode == bbf_pkg::op_compare_regs) ||
    (i_opcode == bbf_pkg::op_compare_with_borrow) || (i_opcode == bbf_pkg::op_compare_immediate);
  assign is_shift = (i_opcode >= bbf_pkg::op_shift_left_zero_fill) &&
    (i_opcode <= bbf_pkg::op_arith_shift_right);

  assign pc_seq = i_pc + PC_W'(bbf_pkg::PC_STEP);
  assign pc_skip = i_pc + (i_skip_long ? PC_W'(bbf_pkg::SKIP_LONG) : PC_W'(bbf_pkg::SKIP_SHORT));
  // Offset is a signed word count in two's complement
  assign pc_branch = pc_seq + {{(PC_W - bbf_pkg::OFFSET_W){i_offset[6]}}, i_offset};

  always_comb
  begin
    alu_bus.a = i_op_a;
    alu_bus.b = i_op_b;
    alu_bus.cin = flags[bbf_pkg::FLAG_C];
    alu_bus.zin = 1'b1;
    case (i_opcode)
      bbf_pkg::op_shift_left_zero_fill: alu_bus.op = bbf_pkg::alu_shl;
      bbf_pkg::op_shift_right_zero_fill: alu_bus.op = bbf_pkg::alu_shr;
      bbf_pkg::op_rotate_left_carry: alu_bus.op = bbf_pkg::alu_rotl;
      bbf_pkg::op_rotate_right_carry: alu_bus.op = bbf_pkg::alu_rotr;
      bbf_pkg::op_arith_shift_right: alu_bus.op = bbf_pkg::alu_shr_arith;
      default: alu_bus.op = bbf_pkg::alu_sub;
    endcase
    if (i_opcode == bbf_pkg::op_compare_with_borrow)
      alu_bus.zin = flags[bbf_pkg::FLAG_Z];
    else if (is_cmp)
      alu_bus.cin = 1'b0;
  end

  always_comb
  begin
    next_state = state;
    next_flags = flags;
    next_pc_next = o_pc_next;
    next_done = 1'b0;
    next_reg_we = 1'b0;
    next_reg_data = o_reg_data;
    next_io_we = 1'b0;
    next_io_data = o_io_data;
    next_pend_io = 1'b0;
    next_taken = taken;
    // A bus write lands first so that an instruction's own flag update wins
    if (i_avs_write && bus_take && i_avs_address == bbf_pkg::ADDR_FLAGS)
      next_flags = i_avs_writedata[7:0];
    case (state)
      bbf_pkg::st_idle:
      begin
        if (accept)
        begin
          next_pc_next = pc_seq;
          next_done = 1'b1;
          next_taken = 1'b0;
          if (is_cmp)
          begin
            next_flags[bbf_pkg::FLAG_Z] = alu_bus.z;
            next_flags[bbf_pkg::FLAG_N] = alu_bus.n;
            next_flags[bbf_pkg::FLAG_V] = alu_bus.v;
            next_flags[bbf_pkg::FLAG_C] = alu_bus.c;
            next_flags[bbf_pkg::FLAG_H] = alu_bus.h;
          end
          else if (is_shift)
          begin
            next_reg_we = 1'b1;
            next_reg_data = alu_bus.res;
            next_flags[bbf_pkg::FLAG_Z] = alu_bus.z;
            next_flags[bbf_pkg::FLAG_N] = alu_bus.n;
            next_flags[bbf_pkg::FLAG_V] = alu_bus.v;
            next_flags[bbf_pkg::FLAG_C] = alu_bus.c;
          end
          else if (br[4])
          begin
            // Taken branches spend a second cycle refilling the fetch path
            if (flags[br[2:0]] == br[3])
            begin
              next_pc_next = pc_branch;
              next_taken = 1'b1;
              next_done = 1'b0;
              next_state = bbf_pkg::st_hold;
            end
          end
          else if (fl[4])
            next_flags[fl[2:0]] = fl[3];
          else
          begin
            case (i_opcode)
              bbf_pkg::op_skip_reg_bit_clear, bbf_pkg::op_skip_reg_bit_set:
              begin
                if (i_op_a[i_bit_sel] == (i_opcode == bbf_pkg::op_skip_reg_bit_set))
                begin
                  next_pc_next = pc_skip;
                  next_taken = 1'b1;
                  next_done = 1'b0;
                  next_state = bbf_pkg::st_hold;
                end
              end
              bbf_pkg::op_skip_io_bit_clear, bbf_pkg::op_skip_io_bit_set:
              begin
                if (i_io_value[i_bit_sel] == (i_opcode == bbf_pkg::op_skip_io_bit_set))
                begin
                  next_pc_next = pc_skip;
                  next_taken = 1'b1;
                  next_done = 1'b0;
                  next_state = bbf_pkg::st_hold;
                end
              end
              bbf_pkg::op_set_io_bit, bbf_pkg::op_clear_io_bit:
              begin
                next_io_data = i_io_value;
                next_io_data[i_bit_sel] = (i_opcode == bbf_pkg::op_set_io_bit);
                next_pend_io = 1'b1;
                next_done = 1'b0;
                next_state = bbf_pkg::st_hold;
              end
              bbf_pkg::op_nibble_swap:
              begin
                next_reg_we = 1'b1;
                next_reg_data = {i_op_a[3:0], i_op_a[7:4]};
              end
              bbf_pkg::op_store_bit_to_transfer:
                next_flags[bbf_pkg::FLAG_T] = i_op_a[i_bit_sel];
              bbf_pkg::op_load_bit_from_transfer:
              begin
                next_reg_we = 1'b1;
                next_reg_data = i_op_a;
                next_reg_data[i_bit_sel] = flags[bbf_pkg::FLAG_T];
              end
              default:
                next_done = 1'b1;
            endcase
          end
        end
      end
      bbf_pkg::st_hold:
      begin
        next_done = 1'b1;
        next_io_we = pend_io;
        next_state = bbf_pkg::st_idle;
      end
      default:
        next_state = bbf_pkg::st_idle;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      state <= bbf_pkg::st_idle;
      flags <= bbf_pkg::FLAGS_RESET;
      o_pc_next <= '0;
      o_done <= 1'b0;
      o_reg_we <= 1'b0;
      o_reg_data <= 8'h00;
      o_io_we <= 1'b0;
      o_io_data <= 8'h00;
      pend_io <= 1'b0;
      taken <= 1'b0;
    end
    else
    begin
      state <= next_state;
      flags <= next_flags;
      o_pc_next <= next_pc_next;
      o_done <= next_done;
      o_reg_we <= next_reg_we;
      o_reg_data <= next_reg_data;
      o_io_we <= next_io_we;
      o_io_data <= next_io_data;
      pend_io <= next_pend_io;
      taken <= next_taken;
    end
  end

  // Every access takes one wait cycle; read data are captured in that cycle
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~bus_take;

  always_comb
  begin
    next_bus_take = (i_avs_read | i_avs_write) & ~bus_take;
    next_readdata = o_avs_readdata;
    if (i_avs_read && !bus_take)
    begin
      case (i_avs_address)
        bbf_pkg::ADDR_FLAGS: next_readdata = {24'h000000, flags};
        bbf_pkg::ADDR_LAST_PC: next_readdata = 32'(o_pc_next);
        bbf_pkg::ADDR_STATUS:
        begin
          next_readdata = 32'h00000000;
          next_readdata[bbf_pkg::STAT_BUSY] = ~o_exec_ready;
          next_readdata[bbf_pkg::STAT_TAKEN] = taken;
        end
        default: next_readdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      bus_take <= 1'b0;
      o_avs_readdata <= 32'h00000000;
    end
    else
    begin
      bus_take <= next_bus_take;
      o_avs_readdata <= next_readdata;
    end
  end

  cmp_no_write_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    accept && is_cmp |=> o_done && !o_reg_we && !o_io_we && o_exec_ready)
    else $error("compare wrote a register or took more than one cycle");

  cmp_equal_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    accept && i_opcode == bbf_pkg::op_compare_regs && i_op_a == i_op_b
    |=> o_flags[bbf_pkg::FLAG_Z] && !o_flags[bbf_pkg::FLAG_C])
    else $error("equal compare left Z clear or C set");

  skip_target_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    accept && i_opcode == bbf_pkg::op_skip_reg_bit_set && i_op_a[i_bit_sel]
    |=> !o_done ##1 o_done && o_pc_next == PC_W'(int'($past(i_pc, 2)) +
      ($past(i_skip_long, 2) ? bbf_pkg::SKIP_LONG : bbf_pkg::SKIP_SHORT)))
    else $error("register bit skip target wrong");

  branch_eq_taken_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    accept && i_opcode == bbf_pkg::op_branch_equal && flags[bbf_pkg::FLAG_Z]
    |=> !o_exec_ready ##1 o_done && o_pc_next == PC_W'(int'($past(i_pc, 2)) +
      int'($signed($past(i_offset, 2))) + bbf_pkg::PC_STEP))
    else $error("taken equal branch target or timing wrong");

  ovf_not_taken_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    accept && i_opcode == bbf_pkg::op_branch_overflow_clear && flags[bbf_pkg::FLAG_V]
    |=> o_done && o_pc_next == PC_W'(int'($past(i_pc)) + bbf_pkg::PC_STEP))
    else $error("untaken overflow branch not one cycle");

  io_bit_set_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    accept && i_opcode == bbf_pkg::op_set_io_bit
    |=> !o_io_we ##1 o_io_we && o_done && o_io_data == ($past(i_io_value, 2) |
      (8'h01 << $past(i_bit_sel, 2))))
    else $error("I/O bit set wrong value or timing");

  shl_result_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    accept && i_opcode == bbf_pkg::op_shift_left_zero_fill
    |=> o_reg_we && o_reg_data == {$past(i_op_a[6:0]), 1'b0} &&
      o_flags[bbf_pkg::FLAG_C] == $past(i_op_a[7]))
    else $error("left shift result or carry wrong");

  rotl_carry_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    accept && i_opcode == bbf_pkg::op_rotate_left_carry
    |=> o_reg_data[0] == $past(flags[bbf_pkg::FLAG_C]) &&
      o_flags[bbf_pkg::FLAG_C] == $past(i_op_a[7]))
    else $error("rotate left carry path wrong");

  bit_store_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    accept && i_opcode == bbf_pkg::op_store_bit_to_transfer
    |=> o_flags[bbf_pkg::FLAG_T] == $past(i_op_a[i_bit_sel]) && !o_reg_we)
    else $error("bit store did not reach T");

endmodule

// >>> tb/tb_branch_bit_flag_execution.sv
// Self-checking bench for the branch, bit and flag executor.
// Assumes bbf_pkg and bbf_exec are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error at %0t ns: got %h, expected %h", $time, (got), (exp)); end end
module tb_branch_bit_flag_execution;
  // Row: status_flags_register, a, b or io, {long, bit}, offset, pc, status_flags_register, {reg_we, io_we}, data
  typedef struct {
    bbf_pkg::opcode_t op;
    logic [63:0] v;
  } row_t;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_exec_valid = 1'b0;
  bbf_pkg::opcode_t i_opcode = bbf_pkg::op_compare_regs;
  logic [7:0] i_op_a = 8'h00;
  logic [7:0] i_op_b = 8'h00;
  logic [7:0] i_io_value = 8'h00;
  logic [2:0] i_bit_sel = 3'h0;
  logic [6:0] i_offset = 7'h00;
  logic i_skip_long = 1'b0;
  logic [15:0] i_pc = 16'h0080;
  logic [1:0] i_avs_address = 2'h0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0000_0000;
  logic o_exec_ready, o_done, o_reg_we, o_io_we, o_avs_waitrequest;
  logic [15:0] o_pc_next;
  logic [7:0] o_reg_data, o_io_data, o_flags;
  logic [31:0] o_avs_readdata, rd;
  int n_mismatch = 0;
  int compares = 0;
  int n;
  // The pc stays below 0x100 so that every target fits the byte kept in a row
  row_t rows[$] = '{
    '{bbf_pkg::op_compare_regs, 64'h10_05_05_0_00_81_12_0_00},
    '{bbf_pkg::op_compare_with_borrow, 64'h03_10_0F_0_00_81_22_0_00},
    '{bbf_pkg::op_compare_immediate, 64'h00_00_01_0_00_81_25_0_00},
    '{bbf_pkg::op_compare_immediate, 64'h00_80_01_0_00_81_28_0_00},
    '{bbf_pkg::op_skip_reg_bit_clear, 64'h5A_FE_00_0_00_82_5A_0_00},
    '{bbf_pkg::op_skip_reg_bit_set, 64'h5A_FE_00_0_00_81_5A_0_00},
    '{bbf_pkg::op_skip_reg_bit_set, 64'h5A_80_00_F_00_83_5A_0_00},
    '{bbf_pkg::op_skip_io_bit_clear, 64'h5A_00_08_3_00_81_5A_0_00},
    '{bbf_pkg::op_skip_io_bit_clear, 64'h5A_00_F7_3_00_82_5A_0_00},
    '{bbf_pkg::op_skip_io_bit_set, 64'h5A_00_08_B_00_83_5A_0_00},
    '{bbf_pkg::op_branch_flag_set, 64'h40_00_00_6_05_86_40_0_00},
    '{bbf_pkg::op_branch_flag_clear, 64'h40_00_00_6_05_81_40_0_00},
    '{bbf_pkg::op_branch_flag_clear, 64'h00_00_00_7_7E_7F_00_0_00},
    '{bbf_pkg::op_branch_equal, 64'h02_00_00_0_05_86_02_0_00},
    '{bbf_pkg::op_branch_not_equal, 64'h02_00_00_0_05_81_02_0_00},
    '{bbf_pkg::op_branch_not_equal, 64'hFD_00_00_0_05_86_FD_0_00},
    '{bbf_pkg::op_branch_carry_set, 64'h01_00_00_0_05_86_01_0_00},
    '{bbf_pkg::op_branch_lower, 64'h00_00_00_0_05_81_00_0_00},
    '{bbf_pkg::op_branch_carry_clear, 64'h00_00_00_0_7E_7F_00_0_00},
    '{bbf_pkg::op_branch_same_or_higher, 64'h01_00_00_0_05_81_01_0_00},
    '{bbf_pkg::op_branch_minus, 64'h04_00_00_0_05_86_04_0_00},
    '{bbf_pkg::op_branch_plus, 64'h04_00_00_0_05_81_04_0_00},
    '{bbf_pkg::op_branch_half_carry_set, 64'h20_00_00_0_05_86_20_0_00},
    '{bbf_pkg::op_branch_half_carry_clear, 64'h20_00_00_0_05_81_20_0_00},
    '{bbf_pkg::op_branch_overflow_clear, 64'h08_00_00_0_05_81_08_0_00},
    '{bbf_pkg::op_branch_overflow_clear, 64'hF7_00_00_0_05_86_F7_0_00},
    '{bbf_pkg::op_branch_irq_enabled, 64'h80_00_00_0_05_86_80_0_00},
    '{bbf_pkg::op_branch_irq_disabled, 64'h80_00_00_0_05_81_80_0_00},
    '{bbf_pkg::op_branch_signed_ge, 64'h00_00_00_0_05_86_00_0_00},
    '{bbf_pkg::op_branch_signed_lt, 64'h00_00_00_0_05_81_00_0_00},
    '{bbf_pkg::op_set_io_bit, 64'h5A_00_00_5_00_81_5A_1_20},
    '{bbf_pkg::op_clear_io_bit, 64'h5A_00_FF_0_00_81_5A_1_FE},
    '{bbf_pkg::op_shift_left_zero_fill, 64'h30_81_00_0_00_81_39_2_02},
    '{bbf_pkg::op_shift_right_zero_fill, 64'h00_01_00_0_00_81_0B_2_00},
    '{bbf_pkg::op_rotate_left_carry, 64'h01_80_00_0_00_81_09_2_01},
    '{bbf_pkg::op_rotate_right_carry, 64'h01_02_00_0_00_81_0C_2_81},
    '{bbf_pkg::op_arith_shift_right, 64'h00_81_00_0_00_81_05_2_C0},
    '{bbf_pkg::op_nibble_swap, 64'hFF_3C_00_0_00_81_FF_2_C3},
    '{bbf_pkg::op_status_bit_set, 64'h00_00_00_5_00_81_20_0_00},
    '{bbf_pkg::op_status_bit_clear, 64'hFF_00_00_6_00_81_BF_0_00},
    '{bbf_pkg::op_store_bit_to_transfer, 64'h00_08_00_3_00_81_40_0_00},
    '{bbf_pkg::op_load_bit_from_transfer, 64'h40_00_00_2_00_81_40_2_04},
    '{bbf_pkg::op_load_bit_from_transfer, 64'h00_FF_00_7_00_81_00_2_7F},
    '{bbf_pkg::op_set_carry_flag, 64'h00_00_00_0_00_81_01_0_00},
    '{bbf_pkg::op_clear_carry_flag, 64'hFF_00_00_0_00_81_FE_0_00},
    '{bbf_pkg::op_set_negative_flag, 64'h00_00_00_0_00_81_04_0_00},
    '{bbf_pkg::op_clear_negative_flag, 64'hFF_00_00_0_00_81_FB_0_00},
    '{bbf_pkg::op_set_zero_flag, 64'h00_00_00_0_00_81_02_0_00},
    '{bbf_pkg::op_clear_zero_flag, 64'hFF_00_00_0_00_81_FD_0_00},
    '{bbf_pkg::op_irq_global_on, 64'h00_00_00_0_00_81_80_0_00},
    '{bbf_pkg::op_irq_global_off, 64'hFF_00_00_0_00_81_7F_0_00},
    '{bbf_pkg::op_set_sign_flag, 64'h00_00_00_0_00_81_10_0_00},
    '{bbf_pkg::op_clear_sign_flag, 64'hFF_00_00_0_00_81_EF_0_00},
    '{bbf_pkg::op_set_overflow_flag, 64'h00_00_00_0_00_81_08_0_00}
  };

  bbf_exec #(.PC_W(16)) dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
    .i_exec_valid(i_exec_valid), .o_exec_ready(o_exec_ready), .i_opcode(i_opcode),
    .i_op_a(i_op_a), .i_op_b(i_op_b), .i_io_value(i_io_value), .i_bit_sel(i_bit_sel),
    .i_offset(i_offset), .i_skip_long(i_skip_long), .i_pc(i_pc), .o_done(o_done),
    .o_pc_next(o_pc_next), .o_reg_we(o_reg_we), .o_reg_data(o_reg_data),
    .o_io_we(o_io_we), .o_io_data(o_io_data), .o_flags(o_flags),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest));

  initial
  begin
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  task automatic give_verdict();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic limit();
    if (n >= 20)
    begin
      n_mismatch++;
      give_verdict();
    end
  endtask

  // Outputs are read as they stood just before each edge, so no race with the design
  task automatic bus(input logic wr, input logic [1:0] adr, input logic [31:0] wd);
    @(posedge i_ref_clk);
    i_avs_read <= ~wr;
    i_avs_write <= wr;
    i_avs_address <= adr;
    i_avs_writedata <= wd;
    n = 0;
    while (n == 0 || (o_avs_waitrequest !== 1'b0 && n < 20))
    begin
      @(posedge i_ref_clk);
      n++;
    end
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    limit();
  endtask

  task automatic run(input row_t r);
    bus(1'b1, bbf_pkg::ADDR_FLAGS, {24'h000000, r.v[63:56]});
    @(posedge i_ref_clk);
    i_exec_valid <= 1'b1;
    i_opcode <= r.op;
    i_op_a <= r.v[55:48];
    i_op_b <= r.v[47:40];
    i_io_value <= r.v[47:40];
    i_skip_long <= r.v[39];
    i_bit_sel <= r.v[38:36];
    i_offset <= r.v[34:28];
    n = 0;
    while (n == 0 || (o_exec_ready !== 1'b1 && n < 20))
    begin
      @(posedge i_ref_clk);
      n++;
    end
    limit();
    i_exec_valid <= 1'b0;
    n = 0;
    while (n == 0 || (o_done !== 1'b1 && n < 20))
    begin
      @(posedge i_ref_clk);
      n++;
    end
    limit();
  endtask

  initial
  begin
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    foreach (rows[i])
    begin
      run(rows[i]);
      `CHK(n, (rows[i].v[27:20] != 8'h81 || rows[i].v[8]) ? 2 : 1)
      `CHK(o_pc_next, {8'h00, rows[i].v[27:20]})
      `CHK(o_flags, rows[i].v[19:12])
      `CHK({o_reg_we, o_io_we}, rows[i].v[9:8])
      if (rows[i].v[9])
        `CHK(o_reg_data, rows[i].v[7:0])
      if (rows[i].v[8])
        `CHK(o_io_data, rows[i].v[7:0])
    end
    run('{bbf_pkg::op_branch_irq_disabled, 64'h00_00_00_0_7E_7F_00_0_00});
    bus(1'b0, bbf_pkg::ADDR_STATUS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0002)
    bus(1'b1, bbf_pkg::ADDR_LAST_PC, 32'h0000_1234);
    bus(1'b0, bbf_pkg::ADDR_LAST_PC, 32'h0000_0000);
    `CHK(rd, 32'h0000_007F)
    bus(1'b0, 2'h3, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    bus(1'b1, bbf_pkg::ADDR_FLAGS, 32'hFFFF_FF02);
    bus(1'b0, bbf_pkg::ADDR_FLAGS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0002)
    // Valid stays high across the hold cycle; the second op must wait for it
    @(posedge i_ref_clk);
    i_exec_valid <= 1'b1;
    i_opcode <= bbf_pkg::op_branch_equal;
    i_offset <= 7'h05;
    @(posedge i_ref_clk);
    i_opcode <= bbf_pkg::op_set_carry_flag;
    @(posedge i_ref_clk);
    `CHK({o_done, o_exec_ready}, 2'h0)
    @(posedge i_ref_clk);
    i_exec_valid <= 1'b0;
    `CHK({o_done, o_pc_next}, {1'b1, 16'h0086})
    @(posedge i_ref_clk);
    `CHK({o_done, o_pc_next, o_flags}, {1'b1, 16'h0081, 8'h03})
    @(posedge i_ref_clk);
    `CHK(o_done, 1'b0)
    i_srst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    `CHK({o_exec_ready, o_done, o_flags, o_pc_next}, {2'h2, 8'h00, 16'h0000})
    // The first edge after release must still show idle outputs
    @(posedge i_ref_clk);
    `CHK({o_exec_ready, o_done, o_flags, o_pc_next}, {2'h2, 8'h00, 16'h0000})
    give_verdict();
  end
endmodule
